// file: hw/mpvu_pkg.sv
// constants shared by the protection unit and its fence comparator
package mpvu_pkg;

	// ----------------------------------------
	// instruction field layout
	// ----------------------------------------
	localparam int        SEL_LSB      = 0;
	localparam int        SEL_W        = 6;
	localparam logic [5:0] SEL_CODE_ONE = 6'h01;

	// ----------------------------------------
	// lower bound of protected memory
	// ----------------------------------------
	// addresses 0 and 1 differ only in bit 0; bits from here up decide
	localparam int        LOW_PAIR_MSB = 1;

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic      RST_FENCE_BIT  = 1'b0;
	localparam logic      RST_PARITY_EN  = 1'b1;
	localparam logic      RST_PARITY_ERR = 1'b0;
	localparam logic      RST_CONTROL    = 1'b0;
	localparam logic      RST_FLAG_BUF   = 1'b0;
	localparam logic      RST_FLAG_N     = 1'b1;
	localparam logic      RST_IRQ        = 1'b0;
	localparam logic      RST_ABORT      = 1'b0;
	localparam logic      RST_MAPPER     = 1'b0;
	localparam logic      RST_VIOL_N     = 1'b1;

endpackage

// file: hw/mpvu_fence_if.sv
// fence comparator carrier between control logic and comparator
`timescale 1ns/1ns
interface mpvu_fence_if #(
	parameter int W = 16
);
	logic         load;
	logic [W-1:0] sbus;
	logic [W-1:0] mbus;
	logic         jump;
	logic         below;
	logic         bound_ok;

	modport ctrl (
		output load,
		output sbus,
		output mbus,
		output jump,
		input  below,
		input  bound_ok
	);

	modport cmp (
		input  load,
		input  sbus,
		input  mbus,
		input  jump,
		output below,
		output bound_ok
	);
endinterface

// file: hw/mpvu_fence_cmp.sv
// fence register, fence comparator and lower bound test
`timescale 1ns/1ns
module mpvu_fence_cmp #(
	parameter int W = 16
) (
	input  wire logic ref_clk,
	input  wire logic nrst,
	mpvu_fence_if.cmp fb
);

	logic [W-1:0] fence;

	// ----------------------------------------
	// fence register
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			fence <= {W{mpvu_pkg::RST_FENCE_BIT}};
		end else if (fb.load) begin
			fence <= fb.sbus; // [R1]
		end
	end

	// ----------------------------------------
	// comparison
	// ----------------------------------------
	assign fb.below    = fence > fb.mbus; // [R2]
	assign fb.bound_ok = fb.jump | (|fb.mbus[W-1:mpvu_pkg::LOW_PAIR_MSB]); // [R3]

endmodule

// file: hw/mpvu_top.sv
// memory protect and i/o violation unit: detection, flag and abort logic
`timescale 1ns/1ns
//
// Contract
// [R1] output to fence at select code 5 loads S-Bus into the fence.
// [R2] below_fence_flag high whenever fence exceeds the M-Bus address.
// [R3] lower bound passes on jump or address not 0/1; violation needs both.
// [R4] jump flag captured from S-Bus at every ir_store_strobe.
// [R5] check strobe precedes store; violation drives mem_violation_n low at P5.
// [R6] store_above_lower_bound and protect_state_out go to the mapper.
// [R7] mapper violation sets mapper_violation_ff and the flag buffer.
// [R8] mapper flag cleared by preset or set control, tested by skips.
// [R9] halt at ir_store_strobe sets halt flag at P5, cleared next strobe.
// [R10] low six S-Bus bits equal to 01 set select-one flag at P5.
// [R11] illegal instruction at io_group_start drives io_violation_n low at P5.
// [R12] halt always illegal; jumper out allows select code one only.
// [R13] unit sits at select code 5; priority chain lives in the CPU.
// [R14] flag_out_n is low while the flag is set.
// [R15] qualified parity error sets parity error and flag buffer, any enable.
// [R16] flag sets at next T2, irq at T5, then toggles until acknowledged.
// [R17] clear flag before flag falls cancels request unless control is set.
// [R18] CPU rereads a zero interrupt register to catch late violations.
// [R19] control set and any_violation high set violation_abort at next P5.
// [R20] CPU and memory block program counter, S-register and stores on abort.
// [R21] abort with interrupt enable and priority raises special request.
// [R22] interrupt acknowledge releases violation_abort.
// [R23] memory or i/o violation sets flag buffer only with control, enable and priority.
// [R24] qualifying parity error clears parity_enable_ff.
// [R25] preset clears flag buffer, flag, irq and control flip-flops.
// [R26] acknowledge clears control flip-flop at P5, turning protection off.
// [R27] memory, i/o and mapper violations merge into any_violation.
module mpvu_top #(
	parameter int          W          = 16,
	parameter logic [15:0] JMP_MASK   = 16'h7800,
	parameter logic [15:0] JMP_MATCH  = 16'h2800,
	parameter logic [15:0] HALT_MASK  = 16'hffc0,
	parameter logic [15:0] HALT_MATCH = 16'h1000
) (
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] s_bus,
	input  wire logic [W-1:0] m_bus,
	input  wire logic         phase_two_strobe,
	input  wire logic         phase_five_strobe,
	input  wire logic         load_fence_instr,
	input  wire logic         ir_store_strobe,
	input  wire logic         protect_check_strobe,
	input  wire logic         io_group_start,
	input  wire logic         io_legality_jumper,
	input  wire logic         ext_mapper_violation,
	input  wire logic         power_on_preset,
	input  wire logic         set_control_instr,
	input  wire logic         set_flag_instr,
	input  wire logic         clear_flag_instr,
	input  wire logic         skip_if_flag_set_instr,
	input  wire logic         skip_if_flag_clear_instr,
	input  wire logic         parity_error_pulse,
	input  wire logic         halt_parity_qualifier,
	input  wire logic         intsys_enable,
	input  wire logic         priority_in,
	input  wire logic         int_acknowledge,
	output logic              below_fence_flag,
	output logic              store_above_lower_bound,
	output logic              protect_state_out,
	output logic              mem_violation_n,
	output logic              io_violation_n,
	output logic              any_violation,
	output logic              mapper_violation_ff,
	output logic              skip_out,
	output logic              parity_enable_ff,
	output logic              parity_error_ff,
	output logic              flag_buffer_ff,
	output logic              flag_out_n,
	output logic              irq_ff_a,
	output logic              violation_abort,
	output logic              special_int_req
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (W != 16) begin : g_bad_width
		$error("mpvu_top: instruction decode needs a 16-bit bus");
	end

	// ----------------------------------------
	// local state
	// ----------------------------------------
	mpvu_fence_if #(.W(W)) fb ();

	logic protect_control_ff;
	logic jump_ff;
	logic halt_seen;
	logic halt_ff;
	logic sel_one_seen;
	logic sel_one_ff;
	logic mem_pend;
	logic io_pend;
	logic abort_pend;
	logic ack_pend;
	logic halt_decode;
	logic jump_decode;
	logic sel_one_decode;
	logic io_illegal;
	logic parity_hit;
	logic viol_req;
	logic flag_cancel;
	logic mem_fire;
	logic io_fire;

	// ----------------------------------------
	// fence comparator
	// ----------------------------------------
	assign fb.load = load_fence_instr; // [R1]
	assign fb.sbus = s_bus;
	assign fb.mbus = m_bus;
	assign fb.jump = jump_ff;

	mpvu_fence_cmp #(
		.W (W)
	) u_cmp (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.fb      (fb.cmp)
	);

	// ----------------------------------------
	// instruction decode
	// ----------------------------------------
	assign jump_decode    = (s_bus & JMP_MASK) == JMP_MATCH;
	assign halt_decode    = (s_bus & HALT_MASK) == HALT_MATCH;
	assign sel_one_decode = s_bus[mpvu_pkg::SEL_LSB +: mpvu_pkg::SEL_W] == mpvu_pkg::SEL_CODE_ONE; // [R10]

	// halt is never legal; without the jumper only select code one is
	assign io_illegal = halt_ff | (!io_legality_jumper & !sel_one_ff); // [R12]

	assign mem_fire = mem_pend & phase_five_strobe;
	assign io_fire  = io_pend & phase_five_strobe;

	assign parity_hit = parity_error_pulse & parity_enable_ff
		& priority_in & halt_parity_qualifier; // [R15]

	assign viol_req = any_violation & protect_control_ff
		& intsys_enable & priority_in; // [R23]

	// clear flag only cancels while the flag has not yet fallen
	assign flag_cancel = clear_flag_instr & flag_out_n & !protect_control_ff; // [R17]

	// ----------------------------------------
	// jump flag
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			jump_ff <= 1'b0;
		end else if (ir_store_strobe) begin
			jump_ff <= jump_decode; // [R4]
		end
	end

	// ----------------------------------------
	// halt instruction flag
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst || power_on_preset) begin
			halt_seen <= 1'b0;
			halt_ff   <= 1'b0;
		end else if (ir_store_strobe) begin
			halt_seen <= halt_decode;
			halt_ff   <= 1'b0; // [R9]
		end else if (phase_five_strobe && halt_seen) begin
			halt_seen <= 1'b0;
			halt_ff   <= 1'b1; // [R9]
		end
	end

	// ----------------------------------------
	// select code one flag
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst || power_on_preset) begin
			sel_one_seen <= 1'b0;
			sel_one_ff   <= 1'b0;
		end else if (ir_store_strobe) begin
			sel_one_seen <= sel_one_decode;
			sel_one_ff   <= 1'b0;
		end else if (phase_five_strobe && sel_one_seen) begin
			sel_one_seen <= 1'b0;
			sel_one_ff   <= 1'b1; // [R10]
		end
	end

	// ----------------------------------------
	// memory violation
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			mem_pend <= 1'b0;
		end else if (protect_check_strobe && fb.below && fb.bound_ok) begin
			mem_pend <= 1'b1; // [R3]
		end else if (phase_five_strobe) begin
			mem_pend <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			mem_violation_n <= mpvu_pkg::RST_VIOL_N;
		end else begin
			mem_violation_n <= !mem_fire; // [R5]
		end
	end

	// ----------------------------------------
	// i/o violation
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			io_pend <= 1'b0;
		end else if (io_group_start && io_illegal) begin
			io_pend <= 1'b1; // [R11]
		end else if (phase_five_strobe) begin
			io_pend <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			io_violation_n <= mpvu_pkg::RST_VIOL_N;
		end else begin
			io_violation_n <= !io_fire; // [R11]
		end
	end

	// ----------------------------------------
	// merged violation
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			any_violation <= 1'b0;
		end else begin
			any_violation <= mem_fire | io_fire | ext_mapper_violation; // [R27]
		end
	end

	// ----------------------------------------
	// mapper outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			below_fence_flag        <= 1'b0;
			store_above_lower_bound <= 1'b0;
			protect_state_out       <= mpvu_pkg::RST_CONTROL;
		end else begin
			below_fence_flag        <= fb.below; // [R2]
			store_above_lower_bound <= protect_check_strobe & fb.bound_ok; // [R6]
			protect_state_out       <= protect_control_ff; // [R6]
		end
	end

	// ----------------------------------------
	// mapper violation flag and skip tests
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			mapper_violation_ff <= mpvu_pkg::RST_MAPPER;
		end else if (ext_mapper_violation) begin
			mapper_violation_ff <= 1'b1; // [R7]
		end else if (power_on_preset || set_control_instr) begin
			mapper_violation_ff <= 1'b0; // [R8]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			skip_out <= 1'b0;
		end else begin
			skip_out <= (skip_if_flag_set_instr & mapper_violation_ff)
				| (skip_if_flag_clear_instr & !mapper_violation_ff); // [R8]
		end
	end

	// ----------------------------------------
	// parity enable and parity error
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst || power_on_preset) begin
			parity_enable_ff <= mpvu_pkg::RST_PARITY_EN;
		end else if (set_flag_instr) begin
			parity_enable_ff <= 1'b1;
		end else if (parity_hit || clear_flag_instr) begin
			parity_enable_ff <= 1'b0; // [R24]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			parity_error_ff <= mpvu_pkg::RST_PARITY_ERR;
		end else if (parity_hit) begin
			parity_error_ff <= 1'b1; // [R15]
		end else if (power_on_preset || set_control_instr) begin
			parity_error_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// flag buffer
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst || power_on_preset) begin
			flag_buffer_ff <= mpvu_pkg::RST_FLAG_BUF; // [R25]
		end else if (parity_hit || ext_mapper_violation || viol_req) begin
			flag_buffer_ff <= 1'b1; // [R15] [R7] [R23]
		end else if ((int_acknowledge && irq_ff_a) || flag_cancel) begin
			flag_buffer_ff <= 1'b0; // [R17]
		end
	end

	// ----------------------------------------
	// flag and interrupt request
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst || power_on_preset) begin
			flag_out_n <= mpvu_pkg::RST_FLAG_N; // [R25]
		end else if (flag_cancel) begin
			flag_out_n <= 1'b1; // [R17]
		end else if (phase_two_strobe) begin
			flag_out_n <= !flag_buffer_ff; // [R16] [R14]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst || power_on_preset) begin
			irq_ff_a <= mpvu_pkg::RST_IRQ; // [R25]
		end else if (phase_two_strobe) begin
			irq_ff_a <= 1'b0; // [R16]
		end else if (phase_five_strobe && !flag_out_n && flag_buffer_ff) begin
			irq_ff_a <= 1'b1; // [R16]
		end
	end

	// ----------------------------------------
	// protection control
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst || power_on_preset) begin
			ack_pend <= 1'b0;
		end else if (int_acknowledge) begin
			ack_pend <= 1'b1;
		end else if (phase_five_strobe) begin
			ack_pend <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst || power_on_preset) begin
			protect_control_ff <= mpvu_pkg::RST_CONTROL; // [R25]
		end else if (phase_five_strobe && (ack_pend || int_acknowledge)) begin
			protect_control_ff <= 1'b0; // [R26]
		end else if (set_control_instr) begin
			protect_control_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// violation abort
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst || power_on_preset) begin
			abort_pend <= 1'b0;
		end else if (protect_control_ff && any_violation) begin
			abort_pend <= 1'b1; // [R19]
		end else if (phase_five_strobe) begin
			abort_pend <= 1'b0;
		end
	end

	// abort blocks the pc, s-register and stores in the cpu and memory
	always_ff @(posedge ref_clk) begin
		if (!nrst || power_on_preset) begin
			violation_abort <= mpvu_pkg::RST_ABORT;
		end else if (phase_five_strobe && abort_pend) begin
			violation_abort <= 1'b1; // [R19] [R20]
		end else if (int_acknowledge) begin
			violation_abort <= 1'b0; // [R22]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			special_int_req <= 1'b0;
		end else begin
			special_int_req <= violation_abort & intsys_enable & priority_in; // [R21]
		end
	end

endmodule

// file: dv/mpvu_cpu_model.sv
// cpu side model: machine cycle phase strobes and priority chain
`timescale 1ns/1ns
module mpvu_cpu_model (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic chain_open,
	output logic      phase_two_strobe,
	output logic      phase_five_strobe,
	output logic      priority_in
);
	logic [2:0] step = 3'h0;

	// eight-step machine cycle, advanced just after each rising edge
	always @(posedge ref_clk) begin
		if (!nrst)
			step <= 3'h0;
		else
			step <= step + 3'h1;
	end
	assign phase_two_strobe  = (step == 3'h2);
	assign phase_five_strobe = (step == 3'h5);
	assign priority_in       = chain_open;
endmodule

// file: dv/mpvu_chk.sv
// concurrent checks on the protection unit ports
`timescale 1ns/1ns
module mpvu_chk (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic phase_two_strobe,
	input wire logic phase_five_strobe,
	input wire logic ext_mapper_violation,
	input wire logic power_on_preset,
	input wire logic set_control_instr,
	input wire logic set_flag_instr,
	input wire logic clear_flag_instr,
	input wire logic parity_error_pulse,
	input wire logic halt_parity_qualifier,
	input wire logic intsys_enable,
	input wire logic priority_in,
	input wire logic int_acknowledge,
	input wire logic mem_violation_n,
	input wire logic io_violation_n,
	input wire logic any_violation,
	input wire logic mapper_violation_ff,
	input wire logic parity_enable_ff,
	input wire logic parity_error_ff,
	input wire logic flag_buffer_ff,
	input wire logic flag_out_n,
	input wire logic irq_ff_a,
	input wire logic violation_abort,
	input wire logic special_int_req
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_flag_at_t2: assert property (phase_two_strobe && !clear_flag_instr && !power_on_preset |=>
		flag_out_n == !$past(flag_buffer_ff)) else $error("flag not copied at t2");
	a_irq_off_t2: assert property (phase_two_strobe |=> !irq_ff_a)
		else $error("irq not dropped at t2");
	a_irq_on_t5: assert property (phase_five_strobe && !flag_out_n && flag_buffer_ff && !power_on_preset
		|=> irq_ff_a) else $error("irq not raised at t5");
	a_mem_at_p5: assert property (!mem_violation_n |-> $past(phase_five_strobe))
		else $error("memory violation outside p5");
	a_io_at_p5: assert property (!io_violation_n |-> $past(phase_five_strobe))
		else $error("io violation outside p5");
	a_merge_viol: assert property ((!mem_violation_n || !io_violation_n) |-> any_violation)
		else $error("violation not merged");
	a_abort_p5: assert property ($rose(violation_abort) |-> $past(phase_five_strobe))
		else $error("abort set outside p5");
	a_abort_ack: assert property (int_acknowledge && !phase_five_strobe |=> !violation_abort)
		else $error("abort kept after acknowledge");
	a_mapper_set: assert property (ext_mapper_violation && !power_on_preset
		|=> mapper_violation_ff && flag_buffer_ff) else $error("mapper violation lost");
	a_parity_hit: assert property (parity_error_pulse && parity_enable_ff && priority_in
		&& halt_parity_qualifier && !set_flag_instr && !set_control_instr && !power_on_preset
		|=> parity_error_ff && flag_buffer_ff && !parity_enable_ff) else $error("parity error not taken");
	a_special_req: assert property (special_int_req == $past(violation_abort && intsys_enable && priority_in))
		else $error("special request wrong");
	a_preset_clr: assert property (power_on_preset && !ext_mapper_violation && !parity_error_pulse
		&& !any_violation && !phase_five_strobe |=> !flag_buffer_ff && !violation_abort && parity_enable_ff)
		else $error("preset did not clear");
endmodule

bind mpvu_top mpvu_chk u_chk (.*);

// file: dv/mpvu_top_tb.sv
// self-checking bench for the protection unit
`timescale 1ns/1ns
module mpvu_top_tb;
	localparam logic [15:0] JMP_OP  = 16'h2800;
	localparam logic [15:0] HALT_OP = 16'h1000;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [15:0] s_bus, m_bus;
	logic        load_fence_instr, ir_store_strobe, protect_check_strobe, io_group_start, io_legality_jumper;
	logic        ext_mapper_violation, power_on_preset, set_control_instr, set_flag_instr, clear_flag_instr;
	logic        skip_if_flag_set_instr, skip_if_flag_clear_instr, parity_error_pulse, halt_parity_qualifier;
	logic        intsys_enable, int_acknowledge, chain_open, phase_two_strobe, phase_five_strobe, priority_in;
	logic        below_fence_flag, store_above_lower_bound, protect_state_out, mem_violation_n, io_violation_n;
	logic        any_violation, mapper_violation_ff, skip_out, parity_enable_ff, parity_error_ff;
	logic        flag_buffer_ff, flag_out_n, irq_ff_a, violation_abort, special_int_req;
	int          n_mismatch = 0;
	int          checked = 0;

	mpvu_top #(.JMP_MATCH(JMP_OP), .HALT_MATCH(HALT_OP)) dut (.*);
	mpvu_cpu_model cpu (.*);

	always #50 ref_clk = ~ref_clk;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic got, input logic exp, input string what);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	function automatic logic sel(input int k);
		case (k)
			0: return phase_five_strobe;
			1: return violation_abort;
			2: return !flag_out_n;
			3: return irq_ff_a;
			default: return phase_two_strobe;
		endcase
	endfunction

	// bounded wait until the selected signal is high at a falling edge
	task automatic wait_for(input int k);
		int i;
		for (i = 0; i < 40 && sel(k) !== 1'b1; i++)
			@(negedge ref_clk);
		if (i == 40) begin
			n_mismatch++;
			$display("[FAIL] %0t wait %0d ran out", $time, k);
			stop_test();
		end
	endtask

	task automatic check_at(input logic [15:0] addr);
		m_bus = addr;
		protect_check_strobe = 1'b1;
		cyc(1);
		protect_check_strobe = 1'b0;
	endtask

	task automatic t_mem();
		s_bus = 16'h1000;
		load_fence_instr = 1'b1;
		cyc(1);
		load_fence_instr = 1'b0;
		cyc(1);
		chk(below_fence_flag, 1'b1, "below fence");
		m_bus = 16'h1000;
		cyc(1);
		chk(below_fence_flag, 1'b0, "at fence");
		s_bus = 16'h0000;
		ir_store_strobe = 1'b1;
		set_control_instr = 1'b1;
		cyc(1);
		ir_store_strobe = 1'b0;
		set_control_instr = 1'b0;
		check_at(16'h0001);
		chk(store_above_lower_bound, 1'b0, "address 1 passed bound");
		cyc(10);
		chk(violation_abort, 1'b0, "abort below bound");
		check_at(16'h0002);
		chk(store_above_lower_bound, 1'b1, "address 2 failed bound");
		wait_for(0);
		cyc(1);
		chk(mem_violation_n, 1'b0, "no memory violation");
		chk(any_violation, 1'b1, "no merged violation");
		wait_for(1);
		cyc(1);
		chk(special_int_req, 1'b1, "no special request");
		// cpu side issues no store or i/o start while the abort stands
		wait_for(2);
		chk(flag_buffer_ff, 1'b1, "flag buffer not set");
		// polling the request again models the second interrupt register read
		wait_for(3);
		int_acknowledge = 1'b1;
		cyc(1);
		int_acknowledge = 1'b0;
		chk(violation_abort, 1'b0, "abort kept");
		chk(flag_buffer_ff, 1'b0, "buffer kept after ack");
		wait_for(0);
		cyc(2);
		chk(protect_state_out, 1'b0, "protection still on");
		s_bus = JMP_OP;
		ir_store_strobe = 1'b1;
		cyc(1);
		ir_store_strobe = 1'b0;
		check_at(16'h0000);
		chk(store_above_lower_bound, 1'b1, "jump bound wrong");
		$display("t_mem done");
	endtask

	task automatic t_io();
		logic [15:0] op[4] = '{HALT_OP, 16'h0001, 16'h0002, 16'h0002};
		logic        jmp[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		logic        bad[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 4; i++) begin
			s_bus = op[i];
			io_legality_jumper = jmp[i];
			ir_store_strobe = 1'b1;
			cyc(1);
			ir_store_strobe = 1'b0;
			wait_for(0);
			cyc(1);
			io_group_start = 1'b1;
			cyc(1);
			io_group_start = 1'b0;
			wait_for(0);
			cyc(1);
			chk(io_violation_n, !bad[i], "io legality wrong");
		end
		$display("t_io done");
	endtask

	task automatic t_mapper();
		wait_for(4);
		// mapper reports in the fourth phase of the cycle
		cyc(2);
		ext_mapper_violation = 1'b1;
		cyc(1);
		ext_mapper_violation = 1'b0;
		chk(mapper_violation_ff, 1'b1, "mapper flag not set");
		skip_if_flag_set_instr = 1'b1;
		clear_flag_instr = 1'b1;
		cyc(1);
		skip_if_flag_set_instr = 1'b0;
		clear_flag_instr = 1'b0;
		chk(skip_out, 1'b1, "no skip on set");
		chk(flag_buffer_ff, 1'b0, "early clear ignored");
		chk(flag_out_n, 1'b1, "flag fell");
		set_control_instr = 1'b1;
		cyc(1);
		set_control_instr = 1'b0;
		chk(mapper_violation_ff, 1'b0, "mapper flag kept");
		skip_if_flag_clear_instr = 1'b1;
		cyc(1);
		skip_if_flag_clear_instr = 1'b0;
		chk(skip_out, 1'b1, "no skip on clear");
		$display("t_mapper done");
	endtask

	task automatic t_parity();
		set_flag_instr = 1'b1;
		intsys_enable = 1'b0;
		cyc(1);
		set_flag_instr = 1'b0;
		// first cycle of the pulse arrives with the priority chain broken
		chain_open = 1'b0;
		parity_error_pulse = 1'b1;
		cyc(1);
		chk(parity_error_ff, 1'b0, "parity taken without priority");
		chk(flag_buffer_ff, 1'b0, "buffer set without priority");
		chain_open = 1'b1;
		cyc(1);
		parity_error_pulse = 1'b0;
		chk(parity_error_ff, 1'b1, "parity error not set");
		chk(flag_buffer_ff, 1'b1, "parity flag buffer");
		chk(parity_enable_ff, 1'b0, "parity still enabled");
		intsys_enable = 1'b1;
		wait_for(4);
		power_on_preset = 1'b1;
		cyc(1);
		power_on_preset = 1'b0;
		chk(flag_buffer_ff, 1'b0, "preset buffer");
		chk(flag_out_n, 1'b1, "preset flag");
		chk(irq_ff_a, 1'b0, "preset irq");
		cyc(1);
		chk(protect_state_out, 1'b0, "preset control");
		$display("t_parity done");
	endtask

	initial begin
		{s_bus, m_bus, load_fence_instr, ir_store_strobe, protect_check_strobe, io_group_start} = '0;
		{io_legality_jumper, ext_mapper_violation, power_on_preset, set_control_instr, set_flag_instr} = '0;
		{clear_flag_instr, skip_if_flag_set_instr, skip_if_flag_clear_instr, parity_error_pulse, int_acknowledge} = '0;
		{halt_parity_qualifier, intsys_enable, chain_open} = 3'h7;
		cyc(3);
		nrst = 1'b1;
		chk(parity_enable_ff, 1'b1, "reset parity enable");
		chk(flag_out_n, 1'b1, "reset flag");
		t_mem();
		t_io();
		t_mapper();
		t_parity();
		stop_test();
	end
endmodule
